// ### hw/cpu_addr_map.vh
// Constants of the addressing-mode decoder: prefix bytes, opcode rows, mode codes.
// Included by every decoder file; holds definitions only.
`ifndef CPU_ADDR_MAP_VH
`define CPU_ADDR_MAP_VH

// Prefix bytes that may precede an opcode
`define PFX_Y           8'h90
`define PFX_IND_Y       8'h91
`define PFX_IND         8'h92

// Prefix kinds as kept by the decoder; bit 1 marks an indirect form
`define PK_NONE         2'h0
`define PK_Y            2'h1
`define PK_IND          2'h2
`define PK_IND_Y        2'h3

// Inherent control opcodes
`define OPC_MASK_RAISE  8'h9B
`define OPC_MASK_LOWER  8'h9A
`define OPC_WAIT        8'h8F
`define OPC_HALT        8'h8E

// Interrupt mask levels
`define MASK_LEVEL_MAX  2'h3
`define MASK_LEVEL_MIN  2'h0
`define MASK_LEVEL_RST  2'h3

// Opcode rows, selected by the upper nibble
`define ROW_BIT_REL     4'h0
`define ROW_BIT         4'h1
`define ROW_REL         4'h2
`define ROW_RMW_DIR     4'h3
`define ROW_RMW_IDX     4'h6
`define ROW_RMW_IDX0    4'h7
`define ROW_IMM         4'hA
`define ROW_DIR         4'hB
`define ROW_LDIR        4'hC
`define ROW_LIDX        4'hD
`define ROW_IDX         4'hE
`define ROW_IDX0        4'hF

// Addressing-mode classes
`define MODE_INH        5'h00
`define MODE_IMM        5'h01
`define MODE_SDIR       5'h02
`define MODE_LDIR       5'h03
`define MODE_IDX0       5'h04
`define MODE_SIDX       5'h05
`define MODE_LIDX       5'h06
`define MODE_SIND       5'h07
`define MODE_LIND       5'h08
`define MODE_SIND_IDX   5'h09
`define MODE_LIND_IDX   5'h0A
`define MODE_REL_DIR    5'h0B
`define MODE_REL_IND    5'h0C
`define MODE_BIT_DIR    5'h0D
`define MODE_BIT_IND    5'h0E
`define MODE_BIT_DREL   5'h0F
`define MODE_BIT_IREL   5'h10

`endif

// ### hw/opcode_mode_class.v
// Opcode classifier: prefix kind and opcode to mode, stream bytes and pointer bytes.
// Purely combinational; the caller supplies a stable opcode and prefix kind.
`timescale 1ns/10ps
`include "cpu_addr_map.vh"

module opcode_mode_class (
  input  wire [1:0] pfx_kind_in,
  input  wire [7:0] opcode_in,
  output reg  [4:0] mode_out,
  output reg  [1:0] arg_bytes_out,
  output reg  [1:0] ptr_bytes_out,
  output reg        rmw_out,
  output reg        use_y_out,
  output reg        illegal_out
);
  reg       ind;
  reg [3:0] row;

  always @* begin
    row           = opcode_in[7:4];
    ind           = pfx_kind_in[1];
    mode_out      = `MODE_INH;
    arg_bytes_out = 2'h0;
    ptr_bytes_out = 2'h0;
    rmw_out       = 1'b0;
    illegal_out   = 1'b0;
    use_y_out     = pfx_kind_in == `PK_Y || pfx_kind_in == `PK_IND_Y;
    case (row)
      `ROW_BIT_REL: begin
        mode_out      = ind ? `MODE_BIT_IREL : `MODE_BIT_DREL;
        arg_bytes_out = 2'h2;
        ptr_bytes_out = {1'b0, ind};
        rmw_out       = 1'b1;
      end
      `ROW_BIT: begin
        mode_out      = ind ? `MODE_BIT_IND : `MODE_BIT_DIR;
        arg_bytes_out = 2'h1;
        ptr_bytes_out = {1'b0, ind};
        rmw_out       = 1'b1;
      end
      `ROW_REL: begin
        mode_out      = ind ? `MODE_REL_IND : `MODE_REL_DIR;
        arg_bytes_out = 2'h1;
        ptr_bytes_out = {1'b0, ind};
      end
      `ROW_RMW_DIR, `ROW_DIR: begin
        mode_out      = ind ? `MODE_SIND : `MODE_SDIR;
        arg_bytes_out = 2'h1;
        ptr_bytes_out = {1'b0, ind};
        rmw_out       = row == `ROW_RMW_DIR;
      end
      `ROW_RMW_IDX, `ROW_IDX: begin
        mode_out      = ind ? `MODE_SIND_IDX : `MODE_SIDX;
        arg_bytes_out = 2'h1;
        ptr_bytes_out = {1'b0, ind};
        rmw_out       = row == `ROW_RMW_IDX;
      end
      `ROW_RMW_IDX0, `ROW_IDX0: begin
        mode_out      = `MODE_IDX0;
        illegal_out   = ind;
        rmw_out       = row == `ROW_RMW_IDX0;
      end
      `ROW_LDIR: begin
        mode_out      = ind ? `MODE_LIND : `MODE_LDIR;
        arg_bytes_out = ind ? 2'h1 : 2'h2;
        ptr_bytes_out = ind ? 2'h2 : 2'h0;
      end
      `ROW_LIDX: begin
        mode_out      = ind ? `MODE_LIND_IDX : `MODE_LIDX;
        arg_bytes_out = ind ? 2'h1 : 2'h2;
        ptr_bytes_out = ind ? 2'h2 : 2'h0;
      end
      `ROW_IMM: begin
        mode_out      = `MODE_IMM;
        arg_bytes_out = 2'h1;
        illegal_out   = ind;
      end
      default: begin
        illegal_out   = ind;
      end
    endcase
    // The Y-indirect prefix only retargets indexed indirect forms
    if (pfx_kind_in == `PK_IND_Y && mode_out != `MODE_SIND_IDX && mode_out != `MODE_LIND_IDX) begin
      illegal_out = 1'b1;
    end
  end
endmodule

// ### hw/ea_former.v
// Effective-address and branch-target former for the addressing-mode decoder.
// Combinational; operands are held stable by the caller while it samples the result.
`timescale 1ns/10ps
`include "cpu_addr_map.vh"

module ea_former (
  input  wire [4:0]  mode_in,
  input  wire [7:0]  index_in,
  input  wire [7:0]  arg0_in,
  input  wire [7:0]  arg1_in,
  input  wire [15:0] ptr_in,
  input  wire [15:0] pc_next_in,
  output reg  [15:0] ea_out,
  output reg  [15:0] target_out
);
  wire [15:0] idx16  = {8'h00, index_in};
  wire [15:0] word   = {arg0_in, arg1_in};
  wire [15:0] ptr_lo = {8'h00, ptr_in[7:0]};

  always @* begin
    ea_out     = 16'h0000;
    target_out = pc_next_in;
    case (mode_in)
      `MODE_SDIR, `MODE_BIT_DIR: ea_out = {8'h00, arg0_in};
      `MODE_LDIR:     ea_out = word;
      `MODE_IDX0:     ea_out = idx16;
      // Both terms are zero-extended, so the sum reaches 1FE and never wraps
      `MODE_SIDX:     ea_out = idx16 + {8'h00, arg0_in};
      `MODE_LIDX:     ea_out = idx16 + word;
      `MODE_SIND, `MODE_BIT_IND: ea_out = ptr_lo;
      `MODE_LIND:     ea_out = ptr_in;
      `MODE_SIND_IDX: ea_out = idx16 + ptr_lo;
      `MODE_LIND_IDX: ea_out = idx16 + ptr_in;
      `MODE_REL_DIR:  target_out = pc_next_in + {{8{arg0_in[7]}}, arg0_in};
      `MODE_REL_IND:  target_out = pc_next_in + {{8{ptr_in[7]}}, ptr_in[7:0]};
      `MODE_BIT_DREL: begin
        ea_out     = {8'h00, arg0_in};
        target_out = pc_next_in + {{8{arg1_in[7]}}, arg1_in};
      end
      `MODE_BIT_IREL: begin
        ea_out     = ptr_lo;
        target_out = pc_next_in + {{8{arg1_in[7]}}, arg1_in};
      end
      default: begin
        ea_out     = 16'h0000;
        target_out = pc_next_in;
      end
    endcase
  end
endmodule

// ### hw/cpu_addressing_mode_decode.v
// Addressing-mode decoder: takes the fetched byte stream, gathers operand bytes,
// reads page-zero pointers and reports length, mode, effective address and target.
// Assumes the fetch unit offers one byte at a time with its address, and a memory
// port that answers each read with an acknowledge; interrupt request is a held level.
// Index registers are sampled only in the finish cycle, so the core holds them from the opcode on.
// A word pointer at 00FF takes its low byte from 0100; the address is not wrapped inside page zero.
//
// Behaviour
// - Long modes form any operand address in the 64 Kbyte space.
// - Short direct and short indirect modes reach page zero only, 0000h to 00FFh.
// - Read-modify-write instructions decode only with short addressing forms.
// - Inherent instructions are one byte, or two with prefix 90; no byte after the opcode is fetched.
// - Immediate instructions take one operand byte used as the value.
// - Short direct takes one address byte, reaching 00 to FF.
// - Long direct takes a two-byte address word, high byte first.
// - Indexed address is the unsigned sum of X or Y and offset.
// - Indexed without offset fetches nothing and uses the index alone.
// - Short indexed adds one offset byte without wrap, reaching 1FE.
// - Long indexed adds a two-byte offset word to the index.
// - Mask-raise instruction sets the interrupt mask to level 3.
// - Mask-lower instruction returns the interrupt mask to level 0.
// - Wait instruction enters a low-power wait ended by an interrupt.
// - Halt instruction stops the oscillator, lowest-power mode.
// - Relative modes add a signed 8-bit offset, direct or from memory.
// - Short indirect reads a one-byte pointer from page zero.
// - Long indirect reads a two-byte pointer word from page zero.
// - Prefix 90 selects Y, 92 indirect, 91 indirect with Y.
`timescale 1ns/10ps
`include "cpu_addr_map.vh"

module cpu_addressing_mode_decode (
  input  wire        clock_in,
  input  wire        rst_n_in,
  input  wire        byte_valid_in,
  input  wire [7:0]  byte_in,
  input  wire [15:0] byte_pc_in,
  output wire        byte_ready_out,
  input  wire [7:0]  x_in,
  input  wire [7:0]  y_in,
  output wire        mem_rd_out,
  output wire [15:0] mem_addr_out,
  input  wire        mem_ack_in,
  input  wire [7:0]  mem_rdata_in,
  input  wire        irq_in,
  output wire        done_out,
  output wire [7:0]  opcode_out,
  output wire [4:0]  mode_out,
  output wire [2:0]  instr_len_out,
  output wire [15:0] ea_out,
  output wire [7:0]  operand_out,
  output wire [15:0] rel_target_out,
  output wire        rmw_out,
  output wire        use_y_out,
  output wire        illegal_out,
  output wire [1:0]  mask_level_out,
  output wire        wait_state_out,
  output wire        osc_stop_out
);
  localparam [2:0] S_FIRST = 3'h0;
  localparam [2:0] S_OPC   = 3'h1;
  localparam [2:0] S_ARG   = 3'h2;
  localparam [2:0] S_MEM   = 3'h3;
  localparam [2:0] S_FIN   = 3'h4;
  localparam [2:0] S_LOW   = 3'h5;

  // Instruction being gathered
  reg [2:0]  state_ff;
  reg [1:0]  pfx_ff;
  reg        pfx_seen_ff;
  reg [7:0]  opc_ff;
  reg [15:0] pc_ff;
  reg [7:0]  arg0_ff;
  reg [7:0]  arg1_ff;
  reg [1:0]  arg_cnt_ff;
  reg [15:0] ptr_ff;
  reg [1:0]  ptr_cnt_ff;
  reg [15:0] mem_addr_ff;

  // Results other than done stand from one finish to the next, so the core may sample them late
  reg        done_ff;
  reg [7:0]  opcode_ff;
  reg [4:0]  mode_ff;
  reg [2:0]  len_ff;
  reg [15:0] ea_ff;
  reg [7:0]  operand_ff;
  reg [15:0] target_ff;
  reg        rmw_ff;
  reg        use_y_ff;
  reg        illegal_ff;

  // Mask and low-power state outlive single instructions
  reg [1:0]  mask_level_ff;
  reg        wait_ff;
  reg        halt_ff;

  wire        opc_phase = state_ff == S_FIRST || state_ff == S_OPC;
  wire [7:0]  cls_opc   = opc_phase ? byte_in : opc_ff;
  wire [1:0]  cls_pfx   = state_ff == S_FIRST ? `PK_NONE : pfx_ff;
  wire [4:0]  cls_mode;
  wire [1:0]  cls_args;
  wire [1:0]  cls_ptrs;
  wire        cls_rmw;
  wire        cls_use_y;
  wire        cls_illegal;
  wire [15:0] calc_ea;
  wire [15:0] calc_target;

  // A stalled core takes no bytes while waiting or halted
  assign byte_ready_out = opc_phase || state_ff == S_ARG;
  wire   take           = byte_valid_in && byte_ready_out;
  assign mem_rd_out     = state_ff == S_MEM;

  wire [1:0]  arg_cnt_nx = arg_cnt_ff + 2'h1;
  wire [1:0]  ptr_cnt_nx = ptr_cnt_ff + 2'h1;
  // Pointer address is always the first operand byte; it may be arriving now
  wire [7:0]  ptr_base   = arg_cnt_ff == 2'h0 ? byte_in : arg0_ff;
  wire [2:0]  calc_len   = {2'h0, pfx_seen_ff} + 3'h1 + {1'b0, cls_args};
  wire [15:0] pc_next    = pc_ff + {13'h0000, calc_len};
  wire [7:0]  index_sel  = cls_use_y ? y_in : x_in;
  // Control opcodes act only in their legal inherent form, unprefixed or with the Y prefix 90
  wire        ctl_ok     = cls_mode == `MODE_INH && !cls_illegal && !pfx_ff[1];
  wire        do_raise   = ctl_ok && opc_ff == `OPC_MASK_RAISE;
  wire        do_lower   = ctl_ok && opc_ff == `OPC_MASK_LOWER;
  wire        do_wait    = ctl_ok && opc_ff == `OPC_WAIT;
  wire        do_halt    = ctl_ok && opc_ff == `OPC_HALT;

  opcode_mode_class u_class (
    .pfx_kind_in   (cls_pfx),
    .opcode_in     (cls_opc),
    .mode_out      (cls_mode),
    .arg_bytes_out (cls_args),
    .ptr_bytes_out (cls_ptrs),
    .rmw_out       (cls_rmw),
    .use_y_out     (cls_use_y),
    .illegal_out   (cls_illegal)
  );

  ea_former u_ea (
    .mode_in    (cls_mode),
    .index_in   (index_sel),
    .arg0_in    (arg0_ff),
    .arg1_in    (arg1_ff),
    .ptr_in     (ptr_ff),
    .pc_next_in (pc_next),
    .ea_out     (calc_ea),
    .target_out (calc_target)
  );

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_ff      <= S_FIRST;
      pfx_ff        <= `PK_NONE;
      pfx_seen_ff   <= 1'b0;
      opc_ff        <= 8'h00;
      pc_ff         <= 16'h0000;
      arg0_ff       <= 8'h00;
      arg1_ff       <= 8'h00;
      arg_cnt_ff    <= 2'h0;
      ptr_ff        <= 16'h0000;
      ptr_cnt_ff    <= 2'h0;
      mem_addr_ff   <= 16'h0000;
      done_ff       <= 1'b0;
      opcode_ff     <= 8'h00;
      mode_ff       <= `MODE_INH;
      len_ff        <= 3'h0;
      ea_ff         <= 16'h0000;
      operand_ff    <= 8'h00;
      target_ff     <= 16'h0000;
      rmw_ff        <= 1'b0;
      use_y_ff      <= 1'b0;
      illegal_ff    <= 1'b0;
      mask_level_ff <= `MASK_LEVEL_RST;
      wait_ff       <= 1'b0;
      halt_ff       <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        S_FIRST: begin
          if (take) begin
            pc_ff       <= byte_pc_in;
            pfx_ff      <= `PK_NONE;
            pfx_seen_ff <= 1'b0;
            arg_cnt_ff  <= 2'h0;
            if (byte_in == `PFX_Y) begin
              pfx_ff      <= `PK_Y;
              pfx_seen_ff <= 1'b1;
              state_ff    <= S_OPC;
            end else if (byte_in == `PFX_IND) begin
              pfx_ff      <= `PK_IND;
              pfx_seen_ff <= 1'b1;
              state_ff    <= S_OPC;
            end else if (byte_in == `PFX_IND_Y) begin
              pfx_ff      <= `PK_IND_Y;
              pfx_seen_ff <= 1'b1;
              state_ff    <= S_OPC;
            end else begin
              opc_ff   <= byte_in;
              // Inherent and no-offset forms finish on the opcode alone
              state_ff <= cls_args == 2'h0 ? S_FIN : S_ARG;
            end
          end
        end

        // A repeated prefix byte is taken as the opcode itself
        S_OPC: begin
          if (take) begin
            opc_ff   <= byte_in;
            state_ff <= cls_args == 2'h0 ? S_FIN : S_ARG;
          end
        end

        S_ARG: begin
          if (take) begin
            arg_cnt_ff <= arg_cnt_nx;
            if (arg_cnt_ff == 2'h0) begin
              arg0_ff <= byte_in;
            end else begin
              arg1_ff <= byte_in;
            end
            if (arg_cnt_nx == cls_args) begin
              if (cls_ptrs != 2'h0) begin
                // Pointer reads always start in page zero
                mem_addr_ff <= {8'h00, ptr_base};
                ptr_ff      <= 16'h0000;
                ptr_cnt_ff  <= 2'h0;
                state_ff    <= S_MEM;
              end else begin
                state_ff <= S_FIN;
              end
            end
          end
        end

        // Reads run back to back; the address steps only after an acknowledge
        S_MEM: begin
          if (mem_ack_in) begin
            // High byte of a pointer word comes first
            ptr_ff      <= {ptr_ff[7:0], mem_rdata_in};
            ptr_cnt_ff  <= ptr_cnt_nx;
            mem_addr_ff <= mem_addr_ff + 16'h0001;
            if (ptr_cnt_nx == cls_ptrs) begin
              state_ff <= S_FIN;
            end
          end
        end

        S_FIN: begin
          done_ff    <= 1'b1;
          opcode_ff  <= opc_ff;
          mode_ff    <= cls_mode;
          len_ff     <= calc_len;
          ea_ff      <= calc_ea;
          operand_ff <= cls_mode == `MODE_IMM ? arg0_ff : 8'h00;
          target_ff  <= calc_target;
          rmw_ff     <= cls_rmw;
          use_y_ff   <= cls_use_y;
          illegal_ff <= cls_illegal;
          state_ff   <= S_FIRST;
          if (do_raise) begin
            mask_level_ff <= `MASK_LEVEL_MAX;
          end
          if (do_lower) begin
            mask_level_ff <= `MASK_LEVEL_MIN;
          end
          if (do_wait) begin
            wait_ff  <= 1'b1;
            state_ff <= S_LOW;
          end
          if (do_halt) begin
            halt_ff  <= 1'b1;
            state_ff <= S_LOW;
          end
        end

        S_LOW: begin
          // The request line is a held level, so waking a cycle late loses nothing
          if (irq_in) begin
            wait_ff  <= 1'b0;
            halt_ff  <= 1'b0;
            state_ff <= S_FIRST;
          end
        end

        // Unused state codes fall back to the opcode fetch
        default: begin
          state_ff <= S_FIRST;
        end
      endcase
    end
  end

  assign mem_addr_out   = mem_addr_ff;
  assign done_out       = done_ff;
  assign opcode_out     = opcode_ff;
  assign mode_out       = mode_ff;
  assign instr_len_out  = len_ff;
  assign ea_out         = ea_ff;
  assign operand_out    = operand_ff;
  assign rel_target_out = target_ff;
  assign rmw_out        = rmw_ff;
  assign use_y_out      = use_y_ff;
  assign illegal_out    = illegal_ff;
  assign mask_level_out = mask_level_ff;
  assign wait_state_out = wait_ff;
  assign osc_stop_out   = halt_ff;
endmodule

// ### bench/mem_partner.sv
// Memory partner: answers the decoder's pointer reads from a fixed fill pattern.
// Assumes the request is held until acknowledged; delay_in sets the answer latency.
`timescale 1ns/10ps

module mem_partner (
  input  logic        clock_in,
  input  logic        rst_n_in,
  input  logic        rd_in,
  input  logic [15:0] addr_in,
  input  logic [3:0]  delay_in,
  output logic        ack_out,
  output logic [7:0]  rdata_out
);
  logic [3:0] cnt_ff;

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      cnt_ff    <= 4'h0;
      ack_out   <= 1'b0;
      rdata_out <= 8'h00;
    end else if (rd_in && !ack_out && cnt_ff == delay_in) begin
      ack_out   <= 1'b1;
      rdata_out <= addr_in[7:0] ^ 8'hC3 ^ {addr_in[8], 7'h00};
      cnt_ff    <= 4'h0;
    end else begin
      ack_out   <= 1'b0;
      // Data churns outside the acknowledge so a late sample cannot pass by luck
      rdata_out <= ~rdata_out;
      if (rd_in && !ack_out) begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end
endmodule

// ### bench/cpu_addressing_mode_decode_sva.sv
// Checker for the addressing-mode decoder, bound to its top module.
// Sees only the top ports; one clock domain with synchronous reset.
`timescale 1ns/10ps
`include "cpu_addr_map.vh"

module cpu_addressing_mode_decode_sva (
  input logic        clock_in,
  input logic        rst_n_in,
  input logic        byte_ready_out,
  input logic        mem_rd_out,
  input logic [15:0] mem_addr_out,
  input logic        mem_ack_in,
  input logic        irq_in,
  input logic        done_out,
  input logic [7:0]  opcode_out,
  input logic [4:0]  mode_out,
  input logic [2:0]  instr_len_out,
  input logic [15:0] ea_out,
  input logic        rmw_out,
  input logic        use_y_out,
  input logic        illegal_out,
  input logic [1:0]  mask_level_out,
  input logic        wait_state_out,
  input logic        osc_stop_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_mask_raise: assert property (
    done_out && opcode_out == `OPC_MASK_RAISE && mode_out == `MODE_INH && !illegal_out
    |=> mask_level_out == 2'h3) else $error("mask not raised");
  a_mask_lower: assert property (
    done_out && opcode_out == `OPC_MASK_LOWER && mode_out == `MODE_INH && !illegal_out
    |=> mask_level_out == 2'h0) else $error("mask not lowered");
  a_wait_enter: assert property (
    done_out && opcode_out == `OPC_WAIT && mode_out == `MODE_INH && !illegal_out && !irq_in
    |=> wait_state_out && !byte_ready_out) else $error("wait not entered");
  a_halt_enter: assert property (
    done_out && opcode_out == `OPC_HALT && mode_out == `MODE_INH && !illegal_out && !irq_in
    |=> osc_stop_out && !byte_ready_out) else $error("halt not entered");
  a_irq_wake: assert property (
    (wait_state_out || osc_stop_out) && irq_in
    |=> !wait_state_out && !osc_stop_out ##[0:1] byte_ready_out) else $error("no wake");
  a_inherent_len: assert property (
    done_out && mode_out == `MODE_INH && !use_y_out && !illegal_out |-> instr_len_out == 3'h1)
    else $error("inherent length");
  a_short_page0: assert property (
    done_out && (mode_out == `MODE_SDIR || mode_out == `MODE_IDX0) |-> ea_out[15:8] == 8'h00)
    else $error("short address off page zero");
  a_sidx_reach: assert property (
    done_out && mode_out == `MODE_SIDX |-> ea_out <= 16'h01FE) else $error("short index reach");
  a_rmw_short: assert property (
    done_out && rmw_out |-> mode_out != `MODE_LDIR && mode_out != `MODE_LIDX)
    else $error("long form on read-modify-write");
  a_ptr_hold: assert property (
    mem_rd_out && !mem_ack_in |=> mem_rd_out && $stable(mem_addr_out))
    else $error("pointer read dropped");
endmodule

// ### bench/cpu_addressing_mode_decode_bench.sv
// Bench for the addressing-mode decoder: feeds byte streams and checks each result.
// Assumes mem_partner answers pointer reads with its fixed fill pattern.
`timescale 1ns/10ps
`include "cpu_addr_map.vh"

module cpu_addressing_mode_decode_bench;
  logic        clock_in, rst_n_in, byte_valid_in, byte_ready_out, mem_rd_out, mem_ack_in, irq_in;
  logic        done_out, rmw_out, use_y_out, illegal_out, wait_state_out, osc_stop_out;
  logic [1:0]  mask_level_out;
  logic [2:0]  instr_len_out;
  logic [3:0]  mem_delay;
  logic [4:0]  mode_out;
  logic [7:0]  byte_in, x_in, y_in, mem_rdata_in, opcode_out, operand_out;
  logic [15:0] byte_pc_in, mem_addr_out, ea_out, rel_target_out, pc;
  int          err_count, n_compared, cycles;

  cpu_addressing_mode_decode cpu_addressing_mode_decode_i (
    .clock_in, .rst_n_in, .byte_valid_in, .byte_in, .byte_pc_in, .byte_ready_out, .x_in, .y_in,
    .mem_rd_out, .mem_addr_out, .mem_ack_in, .mem_rdata_in, .irq_in, .done_out, .opcode_out,
    .mode_out, .instr_len_out, .ea_out, .operand_out, .rel_target_out, .rmw_out, .use_y_out,
    .illegal_out, .mask_level_out, .wait_state_out, .osc_stop_out);

  mem_partner mem_partner_i (.clock_in, .rst_n_in, .rd_in(mem_rd_out), .addr_in(mem_addr_out),
    .delay_in(mem_delay), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));

  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  // Same fill as the memory partner
  function automatic logic [7:0] pz(input logic [15:0] a);
    return a[7:0] ^ 8'hC3 ^ {a[8], 7'h00};
  endfunction

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("Compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic send(input logic [7:0] b);
    byte_valid_in <= 1'b1;
    byte_in <= b;
    byte_pc_in <= pc;
    pc = pc + 16'h0001;
    @(posedge clock_in);
    while (byte_ready_out !== 1'b1) @(posedge clock_in);
  endtask

  // Bytes go first-highest in bs; outputs are judged in the done cycle
  task automatic run(input int n, input logic [31:0] bs, input logic [4:0] m,
                     input logic [2:0] len, input logic [15:0] ea);
    int k;
    for (k = n - 1; k >= 0; k--) send(bs[8*k +: 8]);
    byte_valid_in <= 1'b0;
    k = 0;
    while (done_out !== 1'b1 && k < 40) begin
      @(posedge clock_in);
      k++;
    end
    chk("done", done_out, 1'b1);
    chk("mode", mode_out, m);
    chk("length", instr_len_out, len);
    chk("address", ea_out, ea);
  endtask

  task automatic sleep_wake(input logic [7:0] opc);
    int k;
    run(1, {24'h000000, opc}, `MODE_INH, 3'h1, 16'h0000);
    repeat (2) @(posedge clock_in);
    chk("wait", wait_state_out, opc == `OPC_WAIT);
    chk("halt", osc_stop_out, opc == `OPC_HALT);
    chk("ready asleep", byte_ready_out, 1'b0);
    irq_in <= 1'b1;
    k = 0;
    while ((wait_state_out | osc_stop_out) !== 1'b0 && k < 10) begin
      @(posedge clock_in);
      k++;
    end
    irq_in <= 1'b0;
    @(posedge clock_in);
    chk("ready awake", byte_ready_out, 1'b1);
  endtask

  task automatic t_control;
    run(1, {24'h000000, `OPC_MASK_LOWER}, `MODE_INH, 3'h1, 16'h0000);
    @(posedge clock_in);
    chk("mask lowered", mask_level_out, 2'h0);
    run(1, {24'h000000, `OPC_MASK_RAISE}, `MODE_INH, 3'h1, 16'h0000);
    @(posedge clock_in);
    chk("mask raised", mask_level_out, 2'h3);
    sleep_wake(`OPC_WAIT);
    sleep_wake(`OPC_HALT);
  endtask

  task automatic t_direct;
    run(2, 32'h0000A655, `MODE_IMM, 3'h2, 16'h0000);
    chk("operand", operand_out, 8'h55);
    run(2, 32'h0000B6FF, `MODE_SDIR, 3'h2, 16'h00FF);
    run(3, 32'h00C6FFFE, `MODE_LDIR, 3'h3, 16'hFFFE);
    chk("rmw long", rmw_out, 1'b0);
    run(2, 32'h00003C10, `MODE_SDIR, 3'h2, 16'h0010);
    chk("rmw direct", rmw_out, 1'b1);
    run(2, 32'h00001520, `MODE_BIT_DIR, 3'h2, 16'h0020);
    chk("rmw bit", rmw_out, 1'b1);
  endtask

  task automatic t_indexed;
    x_in <= 8'hFF;
    y_in <= 8'h20;
    run(1, 32'h000000F6, `MODE_IDX0, 3'h1, 16'h00FF);
    run(2, 32'h0000E6FF, `MODE_SIDX, 3'h2, 16'h01FE);
    run(3, 32'h00D61200, `MODE_LIDX, 3'h3, 16'h12FF);
    run(3, 32'h0090E610, `MODE_SIDX, 3'h3, 16'h0030);
    chk("y chosen", use_y_out, 1'b1);
    run(1, 32'h0000007C, `MODE_IDX0, 3'h1, 16'h00FF);
    chk("rmw indexed", rmw_out, 1'b1);
  endtask

  // Slow answers first, then prompt ones; FF pointer crosses into 0100
  task automatic t_indirect;
    mem_delay <= 4'h3;
    x_in <= 8'hF0;
    y_in <= 8'h01;
    run(3, 32'h0092B610, `MODE_SIND, 3'h3, {8'h00, pz(16'h0010)});
    run(3, 32'h0092C6FF, `MODE_LIND, 3'h3, {pz(16'h00FF), pz(16'h0100)});
    chk("opcode", opcode_out, 8'hC6);
    mem_delay <= 4'h0;
    run(3, 32'h0092E620, `MODE_SIND_IDX, 3'h3, {8'h00, pz(16'h0020)} + 16'h00F0);
    run(3, 32'h0091D620, `MODE_LIND_IDX, 3'h3, {pz(16'h0020), pz(16'h0021)} + 16'h0001);
    chk("prefix allowed", illegal_out, 1'b0);
    run(3, 32'h0092A655, `MODE_IMM, 3'h3, 16'h0000);
    chk("prefix refused", illegal_out, 1'b1);
  endtask

  task automatic t_relative;
    logic [7:0] off;
    pc = 16'h0400;
    run(2, 32'h000020FE, `MODE_REL_DIR, 3'h2, 16'h0000);
    chk("target direct", rel_target_out, 16'h0400);
    pc = 16'h0500;
    off = pz(16'h0010);
    run(3, 32'h00922010, `MODE_REL_IND, 3'h3, 16'h0000);
    chk("target indirect", rel_target_out, 16'h0503 + {{8{off[7]}}, off});
    pc = 16'h0600;
    run(3, 32'h00001005, `MODE_BIT_DREL, 3'h3, 16'h0010);
    chk("target bit", rel_target_out, 16'h0608);
    pc = 16'h0700;
    run(4, 32'h92001005, `MODE_BIT_IREL, 3'h4, {8'h00, pz(16'h0010)});
    chk("target bit indirect", rel_target_out, 16'h0709);
  endtask

  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    // The sequence needs well under a thousand cycles
    if (cycles == 4000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    rst_n_in = 1'b0;
    byte_valid_in = 1'b0;
    byte_in = 8'h00;
    byte_pc_in = 16'h0000;
    x_in = 8'h00;
    y_in = 8'h00;
    irq_in = 1'b0;
    mem_delay = 4'h0;
    pc = 16'h0100;
    repeat (4) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_control();
    t_direct();
    t_indexed();
    t_indirect();
    t_relative();
    finish_test();
  end
endmodule

bind cpu_addressing_mode_decode cpu_addressing_mode_decode_sva cpu_addressing_mode_decode_sva_i (
  .clock_in, .rst_n_in, .byte_ready_out, .mem_rd_out, .mem_addr_out, .mem_ack_in, .irq_in,
  .done_out, .opcode_out, .mode_out, .instr_len_out, .ea_out, .rmw_out, .use_y_out,
  .illegal_out, .mask_level_out, .wait_state_out, .osc_stop_out);
